// [bench/lbc_host_model.sv]
// Host side model: sends legacy binary command frames on the link byte port
`timescale 1ns/10ps
`include "lbc_defs.svh"

module lbc_host_model (
    input  wire logic       clk_i,       // System clock
    output logic [7:0]      rx_byte_o,   // Link byte to the parser
    output logic            rx_valid_o   // Byte strobe, one cycle a byte
);
    initial begin
        rx_byte_o  = 8'h00;
        rx_valid_o = 1'b0;
    end

    // Bad flag corrupts the checksum on purpose
    task automatic send(input logic [7:0] a, c, d1, d2, input bit bad);
        logic [7:0] f [7];
        f = '{a, c, d1, d2, `LBC_FILL_BYTE, `LBC_FILL_BYTE, 8'h00};
        for (int i = 0; i < 6; i++) begin
            f[6] = f[6] + f[i];
        end
        if (bad) begin
            f[6] = ~f[6];
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_i);
            rx_byte_o  <= f[i];
            rx_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        // Released line must not keep showing the last byte
        rx_byte_o  <= ~f[6];
    endtask
endmodule

// [bench/lbc_parser_tb_top.sv]
// Self-checking bench for the legacy binary command parser
`timescale 1ns/10ps
`include "lbc_defs.svh"

module lbc_parser_tb_top;
    localparam int MS = 10;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, rx_valid_i;
    logic nvm_busy_i, reply_valid_o, tx_on_o, tx_pwrup_on_o, temp_shdn_o, busy_o;
    logic [7:0]  wb_adr_i, rx_byte_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0]  wb_sel_i, gain_o, unit_addr;
    logic [15:0] carrier_o, thresh_o;
    lbc_pkg::lbc_reply_t reply_o;
    logic [1:0] txv [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
    logic [1:0] txe [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
    logic verb;
    int num_errors, total_checks, cycles;

    lbc_parser #(.MS_CYCLES(MS), .GAP_CYCLES(200)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .nvm_busy_i(nvm_busy_i),
        .reply_o(reply_o), .reply_valid_o(reply_valid_o), .tx_on_o(tx_on_o),
        .tx_pwrup_on_o(tx_pwrup_on_o), .carrier_o(carrier_o), .thresh_o(thresh_o),
        .gain_o(gain_o), .temp_shdn_o(temp_shdn_o), .busy_o(busy_o));

    lbc_host_model u_host (.clk_i(clk_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check_val(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= d;
        // No timeout of its own: waits for wb_ack_o, only the hang guard ends a missing ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Negative dly skips the latency check
    task automatic frame(input logic [7:0] a, c, d1, d2, input bit bad, want, input int dly);
        int n;
        logic got;
        lbc_pkg::lbc_reply_t r, e;
        n = 0;
        got = 1'b0;
        u_host.send(a, c, d1, d2, bad);
        while (!got && n < (want ? 2600 + dly * MS : 40)) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n == 1) check_val({31'h0, busy_o}, {31'h0, want});
            if (reply_valid_o === 1'b1) begin
                got = 1'b1;
                r = reply_o;
            end
        end
        check_val({31'h0, got}, {31'h0, want});
        if (want && got) begin
            e = '{addr_byte: {unit_addr, 4'h0}, cmd: c, sel: d1, cmd_err: 1'b0, verbose: verb};
            check_val({6'h0, r}, {6'h0, e});
            if (dly >= 0) check_val({31'h0, n >= dly * MS && n <= dly * MS + 6}, 32'h1);
        end
        while (busy_o !== 1'b0 && n < 6000) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
    endtask

    initial begin
        rst_i = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, nvm_busy_i, verb} = 5'h00;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hF;
        unit_addr = 4'h1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0000_0101);
        frame(8'h01, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 0, 1);
        wb_cycle(8'h00, 1'b1, 32'h0000_0007);
        wb_cycle(8'h00, 1'b0, 0); check_val(q, 32'h0000_0007);
        verb = 1'b1;
        frame(8'h01, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 1);
        for (int i = 0; i < 4; i++) begin
            frame(8'h01, `LBC_CMD_TXCTL, {6'h0, txv[i]}, 8'hAA, 0, 1, 1);
            check_val({30'h0, tx_on_o, tx_pwrup_on_o}, {30'h0, txe[i]});
        end
        frame(8'h01, `LBC_CMD_CARRIER, 8'h12, 8'h34, 0, 1, 1);
        check_val({16'h0, carrier_o}, 32'h0000_1234);
        frame(8'h01, `LBC_CMD_THRESH, 8'h0F, 8'hA0, 0, 1, 1);
        check_val({16'h0, thresh_o}, 32'h0000_0FA0);
        frame(8'h01, `LBC_CMD_THRESH, 8'h0E, 8'h10, 0, 1, 1);
        check_val({16'h0, thresh_o}, 32'h0000_0E10);
        frame(8'h01, `LBC_CMD_THRESH, 8'h0F, 8'h0A, 0, 1, 1);
        check_val({16'h0, thresh_o}, 32'h0000_0F0A);
        frame(8'h01, `LBC_CMD_GAIN, 8'hAA, 8'h0F, 0, 1, 1);
        check_val({28'h0, gain_o}, 32'h0000_000F);
        frame(8'h01, `LBC_CMD_GAIN, 8'hAA, 8'h01, 0, 1, 1);
        check_val({28'h0, gain_o}, 32'h0000_0001);
        frame(8'h01, `LBC_CMD_BURST, 8'h01, 8'hAA, 0, 1, 1);
        frame(8'h01, `LBC_CMD_BURST, 8'h00, 8'hAA, 0, 1, 1);
        frame(8'h01, `LBC_CMD_DEVTYPE, 8'h00, 8'hAA, 0, 1, 1);
        frame(8'h01, `LBC_CMD_TEMPLOG, 8'h01, 8'hAA, 0, 1, 1);
        check_val({31'h0, temp_shdn_o}, 32'h0000_0001);
        frame(8'h01, `LBC_CMD_TEMPLOG, 8'h00, 8'hAA, 0, 1, 1);
        check_val({31'h0, temp_shdn_o}, 32'h0000_0000);
        frame(8'h01, `LBC_CMD_ADDRDLY, 8'h01, 8'h05, 0, 1, -1);
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0000_0501);
        frame(8'h01, `LBC_CMD_ADDRDLY, 8'h01, `LBC_DLY_KEEP, 0, 1, -1);
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0000_0501);
        frame(8'h01, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 5);
        frame(8'h01, `LBC_CMD_ADDRDLY, 8'h01, 8'h00, 0, 1, -1);
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0001_0001);
        frame(8'h01, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 256);
        frame(8'h01, `LBC_CMD_ADDRDLY, 8'h01, 8'hFF, 0, 1, -1);
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0001_0001);
        unit_addr = 4'h3;
        frame(8'h01, `LBC_CMD_ADDRDLY, 8'h03, 8'h01, 0, 1, -1);
        wb_cycle(8'h04, 1'b0, 0); check_val(q, 32'h0000_0103);
        frame(8'h03, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 1);
        nvm_busy_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        frame(8'h03, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 5);
        nvm_busy_i <= 1'b0;
        frame(8'h01, `LBC_CMD_CARRIER, 8'h55, 8'h66, 0, 0, 0);
        frame(8'h03, `LBC_CMD_CARRIER, 8'h55, 8'h66, 1, 0, 0);
        check_val({16'h0, carrier_o}, 32'h0000_1234);
        wb_cycle(8'h18, 1'b0, 0); check_val({31'h0, q[0]}, 32'h0000_0001);
        wb_cycle(8'h18, 1'b1, 32'h0000_0001);
        wb_cycle(8'h18, 1'b0, 0); check_val({31'h0, q[0]}, 32'h0000_0000);
        frame(8'h03, 8'h08, 8'hAA, 8'hAA, 0, 0, 0);
        wb_cycle(8'h18, 1'b0, 0); check_val({22'h0, q[15:8], q[1:0]}, 32'h0000_0021);
        wb_cycle(8'h18, 1'b1, 32'h0000_0001);
        wb_cycle(8'h00, 1'b1, 32'h0000_0001);
        verb = 1'b0;
        frame(8'h03, `LBC_CMD_CARRIER, 8'h0A, 8'hBC, 0, 0, 0);
        check_val({16'h0, carrier_o}, 32'h0000_0ABC);
        frame(8'h03, `LBC_CMD_STATUS, 8'hAA, 8'hAA, 0, 1, 1);
        wb_cycle(8'h0C, 1'b1, 32'h0000_0000);
        wb_cycle(8'h0C, 1'b0, 0); check_val(q, 32'h0000_0ABC);
        wb_cycle(8'h00, 1'b1, 32'h0000_0000);
        frame(8'h03, `LBC_CMD_CARRIER, 8'h11, 8'h22, 0, 0, 0);
        check_val({16'h0, carrier_o}, 32'h0000_0ABC);
        end_sim();
    end
endmodule

// [rtl/lbc_defs.svh]
// Constants for the legacy binary command parser: offsets, fields, resets, timing
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH

`define LBC_FRAME_LEN    3'h7
`define LBC_ADDR_MIN     8'h01
`define LBC_ADDR_MAX     8'h0F
`define LBC_FILL_BYTE    8'hAA
`define LBC_ADDR_SHIFT   4

`define LBC_CMD_STATUS   8'h01
`define LBC_CMD_TXCTL    8'h02
`define LBC_CMD_ADDRDLY  8'h03
`define LBC_CMD_CARRIER  8'h04
`define LBC_CMD_THRESH   8'h05
`define LBC_CMD_BURST    8'h06
`define LBC_CMD_DEVTYPE  8'h07
`define LBC_CMD_TEMPLOG  8'h09
`define LBC_CMD_GAIN     8'hFF

`define LBC_DLY_KEEP     8'hAA
`define LBC_DLY_MAX_MS   9'h100
`define LBC_GAIN_MIN     8'h01
`define LBC_GAIN_MAX     8'h0F

`define LBC_REG_CTRL     3'h0
`define LBC_REG_ADDRDLY  3'h1
`define LBC_REG_TX       3'h2
`define LBC_REG_CARRIER  3'h3
`define LBC_REG_THRESH   3'h4
`define LBC_REG_GAIN     3'h5
`define LBC_REG_STATUS   3'h6
`define LBC_REG_TEMPLOG  3'h7

`define LBC_CTRL_ENABLE  0
`define LBC_CTRL_ECHO    1
`define LBC_CTRL_VERBOSE 2
`define LBC_STAT_CMDERR  0

`define LBC_RST_ADDR     4'h1
`define LBC_RST_DELAY    9'h001

`define LBC_CLK_NS       100
`define LBC_MS_NS        1000000
`define LBC_MS_CYCLES    (`LBC_MS_NS / `LBC_CLK_NS)
`define LBC_GAP_MS       5
`define LBC_GAP_CYCLES   (`LBC_GAP_MS * `LBC_MS_CYCLES)
`define LBC_NVM_EXTRA_MS 9'h004

`endif

// [rtl/lbc_parser.sv]
// Legacy binary command frame interpreter with a Wishbone register slave
// Contract
// [RULE1] Frames are interpreted only while legacy_binary_enable is 1.
// [RULE2] Seven bytes: address 1..15, command, three data, unused, sum of bytes 1-6.
// [RULE3] Command codes 01,03,04,05,06,07,09,FF decode to their documented functions.
// [RULE4] Command 02 sets transmitter: 0 off, 1 on, 2/3 off/on at power-on.
// [RULE5] Command 03 takes new address (1..15) and response delay in ms.
// [RULE6] Response delay equals the delay byte in milliseconds, minimum 1 ms.
// [RULE7] Delay byte 00 acts as FF and gives 256 ms.
// [RULE8] Delay byte AA leaves the stored delay unchanged.
// [RULE9] Command 04 assembles carrier frequency, first data byte most significant.
// [RULE10] Command 05 assembles power threshold, first data byte high.
// [RULE11] Host programs threshold 20.1 dB below rating in continuous mode.
// [RULE12] Host keeps burst threshold within 20 dB below rated power.
// [RULE13] Command 06 selector: 00 current burst power, 01 stored min/max.
// [RULE14] Command 07 with selector 00 requests serial number and type.
// [RULE15] Command 09 reads or sets the temperature log.
// [RULE16] Command FF sets gain backoff from second data byte, 1..15.
// [RULE17] Echo setting decides whether set-type commands get any reply.
// [RULE18] Verbose setting chooses reply format on every link.
// [RULE19] Nonvolatile write in progress may stretch the response delay.
// [RULE20] Replies carry the unit address shifted left by four bits.
// [RULE21] Unused and factory data bytes are ignored by the device.
// [RULE22] Foreign address ignored; bad checksum not executed, command error flagged.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "lbc_defs.svh"

module lbc_parser #(
    parameter int MS_CYCLES  = `LBC_MS_CYCLES,
    parameter int GAP_CYCLES = `LBC_GAP_CYCLES
) (
    input  wire logic              clk_i,          // System clock, 10 MHz
    input  wire logic              rst_i,          // Synchronous reset, active high
    input  wire logic [7:0]        wb_adr_i,       // Wishbone byte address
    input  wire logic [31:0]       wb_dat_i,       // Wishbone write data
    input  wire logic [3:0]        wb_sel_i,       // Wishbone byte selects
    input  wire logic              wb_we_i,        // Wishbone write enable
    input  wire logic              wb_cyc_i,       // Wishbone cycle
    input  wire logic              wb_stb_i,       // Wishbone strobe
    output logic [31:0]            wb_dat_o,       // Wishbone read data
    output logic                   wb_ack_o,       // Wishbone acknowledge
    input  wire logic [7:0]        rx_byte_i,      // Received link byte
    input  wire logic              rx_valid_i,     // Received byte strobe
    input  wire logic              nvm_busy_i,     // Nonvolatile write in progress, async
    output lbc_pkg::lbc_reply_t    reply_o,        // Reply descriptor
    output logic                   reply_valid_o,  // Reply due, one-cycle pulse
    output logic                   tx_on_o,        // Transmitter on
    output logic                   tx_pwrup_on_o,  // Transmitter state at power-on
    output logic [15:0]            carrier_o,      // Detected carrier frequency, MHz
    output logic [15:0]            thresh_o,       // Power threshold, 1/100 dBm
    output logic [3:0]             gain_o,         // Gain backoff
    output logic                   temp_shdn_o,    // Temperature shutdown setting
    output logic                   busy_o          // Reply pending
);

    logic [7:0]  frame [0:6];
    logic [2:0]  idx;
    logic        frame_done;
    logic [31:0] gap_cnt;
    logic        nvm_meta;
    logic        nvm_busy;
    logic [2:0]  ctrl;
    logic [3:0]  unit_addr;
    logic [8:0]  delay_ms;
    logic        cmd_err;
    logic [7:0]  last_cmd;
    lbc_pkg::lbc_reply_state_t state;
    logic [8:0]  ms_left;
    logic [31:0] ms_cnt;
    logic        next_reply;

    logic [7:0]  sum6;
    logic        addr_hit;
    logic        sum_ok;
    logic        exec;
    logic        known;
    logic        is_set;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic        wb_req;
    logic        err_set;

    function automatic logic in_range(input logic [7:0] v);
        in_range = (v >= `LBC_ADDR_MIN) && (v <= `LBC_ADDR_MAX);
    endfunction

    assign d1       = frame[2];
    assign d2       = frame[3];
    assign sum6     = frame[0] + frame[1] + frame[2] + frame[3] + frame[4] + frame[5]; // RULE2
    assign addr_hit = (frame[0] == {4'h0, unit_addr}) && in_range(frame[0]); // RULE22
    assign sum_ok   = (sum6 == frame[6]); // RULE2
    assign exec     = frame_done && addr_hit && sum_ok;
    assign err_set  = frame_done && addr_hit && (!sum_ok || !known); // RULE22
    assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Command classification; data byte 3 and byte 6 are only summed into the checksum
    always_comb begin // RULE21
        known  = 1'b1;
        is_set = 1'b0;
        unique case (frame[1]) // RULE3
            `LBC_CMD_STATUS, `LBC_CMD_BURST, `LBC_CMD_DEVTYPE, `LBC_CMD_TEMPLOG: is_set = 1'b0;
            `LBC_CMD_TXCTL, `LBC_CMD_ADDRDLY, `LBC_CMD_CARRIER: is_set = 1'b1;
            `LBC_CMD_THRESH, `LBC_CMD_GAIN: is_set = 1'b1;
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        nvm_meta <= nvm_busy_i;
        nvm_busy <= nvm_meta;
    end

    // Frame assembly; a silent gap resynchronises to a new frame start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx        <= 3'h0;
            frame_done <= 1'b0;
            gap_cnt    <= 32'h0000_0000;
        end else begin
            frame_done <= 1'b0;
            if (!ctrl[`LBC_CTRL_ENABLE] || busy_o) begin // RULE1
                idx <= 3'h0;
            end else if (rx_valid_i) begin
                frame[idx] <= rx_byte_i;
                gap_cnt    <= 32'h0000_0000;
                if (idx == `LBC_FRAME_LEN - 3'h1) begin // RULE2
                    idx        <= 3'h0;
                    frame_done <= 1'b1;
                end else begin
                    idx <= idx + 3'h1;
                end
            end else if (idx != 3'h0) begin
                if (gap_cnt >= 32'(GAP_CYCLES - 1)) begin
                    idx <= 3'h0;
                end else begin
                    gap_cnt <= gap_cnt + 32'h0000_0001;
                end
            end
        end
    end

    // Settings carried by frames
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_addr     <= `LBC_RST_ADDR;
            delay_ms      <= `LBC_RST_DELAY;
            tx_on_o       <= 1'b0;
            tx_pwrup_on_o <= 1'b0;
            carrier_o     <= 16'h0000;
            thresh_o      <= 16'h0000;
            gain_o        <= 4'h0;
            temp_shdn_o   <= 1'b0;
        end else if (exec) begin
            unique case (frame[1])
                `LBC_CMD_TXCTL: begin
                    if (d1[7:2] == 6'h00 && !d1[1]) tx_on_o <= d1[0]; // RULE4
                    if (d1[7:2] == 6'h00 && d1[1]) tx_pwrup_on_o <= d1[0]; // RULE4
                end
                `LBC_CMD_ADDRDLY: begin
                    if (in_range(d1)) unit_addr <= d1[3:0]; // RULE5
                    if (d2 == 8'h00) begin
                        delay_ms <= `LBC_DLY_MAX_MS; // RULE7
                    end else if (d2 == 8'hFF) begin
                        delay_ms <= `LBC_DLY_MAX_MS; // RULE7
                    end else if (d2 != `LBC_DLY_KEEP) begin // RULE8
                        delay_ms <= {1'b0, d2}; // RULE6
                    end
                end
                `LBC_CMD_CARRIER: carrier_o <= {d1, d2}; // RULE9
                `LBC_CMD_THRESH:  thresh_o <= {d1, d2}; // RULE10
                `LBC_CMD_TEMPLOG: begin
                    if (d1[7:1] == 7'h00) temp_shdn_o <= d1[0]; // RULE15
                end
                `LBC_CMD_GAIN: begin
                    if (d2 >= `LBC_GAIN_MIN && d2 <= `LBC_GAIN_MAX) gain_o <= d2[3:0]; // RULE16
                end
                default: ;
            endcase
        end
    end

    // Reply scheduling: wait the programmed delay in whole milliseconds
    always_comb begin
        next_reply = exec && known && (!is_set || ctrl[`LBC_CTRL_ECHO]); // RULE17
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= lbc_pkg::LBC_IDLE;
            ms_left       <= 9'h000;
            ms_cnt        <= 32'h0000_0000;
            reply_valid_o <= 1'b0;
            busy_o        <= 1'b0;
            reply_o       <= '0;
        end else begin
            reply_valid_o <= 1'b0;
            unique case (state)
                lbc_pkg::LBC_IDLE: begin
                    if (next_reply) begin
                        state   <= lbc_pkg::LBC_WAIT;
                        busy_o  <= 1'b1;
                        ms_cnt  <= 32'h0000_0000;
                        // Extra margin while nonvolatile memory is being written
                        ms_left <= nvm_busy ? delay_ms + `LBC_NVM_EXTRA_MS : delay_ms; // RULE19
                        reply_o.cmd     <= frame[1]; // RULE3
                        reply_o.sel     <= d1; // RULE13 RULE14
                        reply_o.verbose <= ctrl[`LBC_CTRL_VERBOSE]; // RULE18
                    end
                end
                lbc_pkg::LBC_WAIT: begin
                    if (ms_cnt >= 32'(MS_CYCLES - 1)) begin
                        ms_cnt <= 32'h0000_0000;
                        if (ms_left == 9'h001) begin
                            state         <= lbc_pkg::LBC_IDLE;
                            busy_o        <= 1'b0;
                            reply_valid_o <= 1'b1;
                            reply_o.addr_byte <= {unit_addr, 4'h0}; // RULE20
                            reply_o.cmd_err   <= cmd_err;
                        end
                        ms_left <= ms_left - 9'h001; // RULE6
                    end else begin
                        ms_cnt <= ms_cnt + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // Control register, command error flag and last command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= 3'b000;
            cmd_err  <= 1'b0;
            last_cmd <= 8'h00;
        end else begin
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[4:2] == `LBC_REG_CTRL) begin
                ctrl <= wb_dat_i[2:0];
            end
            // Hardware set beats a write-one-to-clear in the same cycle
            if (err_set) begin
                cmd_err <= 1'b1; // RULE22
            end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[4:2] == `LBC_REG_STATUS
                         && wb_dat_i[`LBC_STAT_CMDERR]) begin
                cmd_err <= 1'b0;
            end
            if (frame_done && addr_hit) last_cmd <= frame[1];
        end
    end

    // Wishbone slave: single-cycle ack, address bits 7:5 ignored so every address reads one of the eight registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i[4:2])
                    `LBC_REG_CTRL:    wb_dat_o <= {29'h0, ctrl};
                    `LBC_REG_ADDRDLY: wb_dat_o <= {15'h0, delay_ms, 4'h0, unit_addr};
                    `LBC_REG_TX:      wb_dat_o <= {30'h0, tx_pwrup_on_o, tx_on_o};
                    `LBC_REG_CARRIER: wb_dat_o <= {16'h0, carrier_o};
                    `LBC_REG_THRESH:  wb_dat_o <= {16'h0, thresh_o};
                    `LBC_REG_GAIN:    wb_dat_o <= {28'h0, gain_o};
                    `LBC_REG_STATUS:  wb_dat_o <= {16'h0, last_cmd, 6'h0, busy_o, cmd_err};
                    `LBC_REG_TEMPLOG: wb_dat_o <= {31'h0, temp_shdn_o};
                endcase
            end
        end
    end

    // Checks
    enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        !ctrl[`LBC_CTRL_ENABLE] |=> !frame_done)
        else $error("frame completed while disabled");

    frame_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        frame_done |-> idx == 3'h0)
        else $error("frame index not reset after seventh byte");

    bad_sum_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
        frame_done && addr_hit && !sum_ok |=> cmd_err && !busy_o)
        else $error("bad checksum not flagged or executed");

    foreign_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
        frame_done && !addr_hit && !busy_o |=> !busy_o && $stable(unit_addr))
        else $error("foreign frame acted on");

    tx_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        exec && frame[1] == `LBC_CMD_TXCTL && d1 == 8'h01 |=> tx_on_o)
        else $error("transmit on not applied");

    delay_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        exec && frame[1] == `LBC_CMD_ADDRDLY && d2 == `LBC_DLY_KEEP |=> $stable(delay_ms))
        else $error("keep code changed delay");

    delay_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        exec && frame[1] == `LBC_CMD_ADDRDLY && d2 == 8'h00 |=> delay_ms == 9'h100)
        else $error("zero delay not 256 ms");

    carrier_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        exec && frame[1] == `LBC_CMD_CARRIER |=> carrier_o == {$past(d1), $past(d2)})
        else $error("carrier bytes misordered");

    thresh_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        exec && frame[1] == `LBC_CMD_THRESH |=> thresh_o == {$past(d1), $past(d2)})
        else $error("threshold bytes misordered");

    echo_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        !busy_o && exec && is_set && !ctrl[`LBC_CTRL_ECHO] |=> !busy_o)
        else $error("set command scheduled reply with echo off");

    reply_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
        reply_valid_o |-> reply_o.addr_byte == {unit_addr, 4'h0})
        else $error("reply address not shifted");

    gain_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
        exec && frame[1] == `LBC_CMD_GAIN && d2 > `LBC_GAIN_MAX |=> $stable(gain_o))
        else $error("out of range backoff accepted");

    addr_change_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        exec && frame[1] == `LBC_CMD_ADDRDLY && in_range(d1) |=> unit_addr == $past(d1[3:0]))
        else $error("new unit address not taken");

    delay_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        exec && frame[1] == `LBC_CMD_ADDRDLY && d2 != 8'h00 && d2 != 8'hFF
            && d2 != `LBC_DLY_KEEP |=> delay_ms == {1'b0, $past(d2)})
        else $error("delay byte not stored in ms");

    reply_format_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        next_reply |=> reply_o.verbose == $past(ctrl[`LBC_CTRL_VERBOSE]))
        else $error("reply format not taken from verbose setting");

    nvm_stretch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
        next_reply && nvm_busy |=> ms_left == $past(delay_ms) + `LBC_NVM_EXTRA_MS)
        else $error("delay not stretched during memory write");

    temp_log_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        exec && frame[1] == `LBC_CMD_TEMPLOG && d1 == 8'h01 |=> temp_shdn_o)
        else $error("temperature shutdown not set");

    unknown_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        frame_done && addr_hit && sum_ok && !known |=> cmd_err && !busy_o)
        else $error("unknown command not flagged");

endmodule

// [rtl/lbc_parser_unused_note.sv]
// Deliberately empty: the whole parser lives in one design file

// [rtl/lbc_pkg.sv]
// Types shared by the legacy binary command parser
package lbc_pkg;

    typedef enum logic [0:0] {
        LBC_IDLE,
        LBC_WAIT
    } lbc_reply_state_t;

    typedef struct packed {
        logic [7:0] addr_byte;
        logic [7:0] cmd;
        logic [7:0] sel;
        logic       cmd_err;
        logic       verbose;
    } lbc_reply_t;

endpackage
